// *** hw/ifc_card.sv ***
`include "ifc_consts.svh"

// What this block does
// - Flag sets at T2 when buffer high
// - Clear-flag instruction resets flag
// - Buffer set by set-flag, preset, unread data
// - Buffer cleared by clear-flag or acknowledge
// - Request sets at T5 when all true
// - Request resets at T2 unless a T5 sets it in the same cycle
// - Priority out low blocks lower cards
// - Skip on skip-if-set while flag set
// - Restricting jumper: skip-if-clear never skips
// - Input active set and cleared by instructions
// - Guard blocks modifier; clears at T2
// - Inactive input closes port, empties FIFO
// - No input register clear during read
// - Commands only while control set
// - Control rising edge issues first command
// - Device flag ends pending command
// - Next command 100 ns after trigger
// - Control reset forces commands inactive
// - Command is open-collector, active low
// - Indicator lit while command line low
// - Control set/cleared by instructions, reset
// - One 100 ns pulse per flag edge
module ifc_card (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [31:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire ifc_pkg::ifc_instr_t instr_i,
    input wire logic phase_two_strobe_i,
    input wire logic request_phase_strobe_i,
    input wire logic interrupt_acknowledge_i,
    input wire logic preset_io_pulse_i,
    input wire logic global_control_reset_i,
    input wire logic interrupt_system_on_i,
    input wire logic priority_in_i,
    input wire logic interface_read_strobe_i,
    input wire logic register_full_i,
    input wire logic next_command_trigger_i,
    input wire logic device_flag_n_i,
    input wire logic device_command_n_i,
    output logic device_command_n_o,
    output logic device_command_oe_n_o,
    output logic command_led_o,
    output logic flag_edge_pulse_o,
    output logic irq_a_o,
    output logic irq_b_o,
    output logic priority_out_o,
    output logic skip_response_o,
    output logic input_active_o,
    output logic fifo_empty_force_o,
    output logic in_reg_clear_o
);

    localparam logic [`IFC_CNT_W-1:0] PULSE_CYC =
        `IFC_CNT_W'(`IFC_PULSE_CYC);

    logic flag_q;
    logic fbuf_q;
    logic irq_q;
    logic ctl_q;
    logic ctl_prev_q;
    logic active_q;
    logic guard_q;
    logic cmd1_q;
    logic cmd2_q;
    logic restrict_q;
    logic flag_prev_q;
    logic [`IFC_CNT_W-1:0] fp_cnt_q;
    logic trig_prev_q;
    ifc_pkg::ifc_dly_t dly_q;
    logic [`IFC_CNT_W-1:0] dly_cnt_q;
    logic flag_edge;
    logic trig_edge;
    logic own_request_active;
    logic flag_buffer_set_term;
    logic cmd_any;
    logic wb_req;

    assign own_request_active = irq_q;
    assign flag_edge = ~device_flag_n_i & ~flag_prev_q;
    assign trig_edge = next_command_trigger_i & ~trig_prev_q;
    assign cmd_any = cmd1_q | cmd2_q;
    assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // Suppressed while a clear-flag is under way
    assign flag_buffer_set_term = ~flag_q & register_full_i &
        ~instr_i.clear_flag_instr;

    // Classic Wishbone slave, one wait state
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            restrict_q <= 1'(`IFC_CTRL_RESET);
        end else if (wb_req && wb_we_i && wb_sel_i[0] &&
                     wb_adr_i[`IFC_ADR_W-1:0] == `IFC_ADR_CTRL) begin
            restrict_q <= wb_dat_i[`IFC_CTRL_RESTRICT];
        end
    end

    // Unmapped addresses read as zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_req && !wb_we_i) begin
            wb_dat_o <= 32'h0000_0000;
            case (wb_adr_i[`IFC_ADR_W-1:0])
                `IFC_ADR_CTRL: begin
                    wb_dat_o[`IFC_CTRL_RESTRICT] <= restrict_q;
                end
                `IFC_ADR_STAT: begin
                    wb_dat_o[`IFC_ST_FLAG] <= flag_q;
                    wb_dat_o[`IFC_ST_FBUF] <= fbuf_q;
                    wb_dat_o[`IFC_ST_CTL] <= ctl_q;
                    wb_dat_o[`IFC_ST_IRQ] <= irq_q;
                    wb_dat_o[`IFC_ST_ACTIVE] <= active_q;
                    wb_dat_o[`IFC_ST_CMD1] <= cmd1_q;
                    wb_dat_o[`IFC_ST_CMD2] <= cmd2_q;
                    wb_dat_o[`IFC_ST_GUARD] <= guard_q;
                    wb_dat_o[`IFC_ST_FULL] <= register_full_i;
                end
                default: begin
                    wb_dat_o <= 32'h0000_0000;
                end
            endcase
        end
    end

    // Set wins over a coincident clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_q <= 1'b0;
        end else if (phase_two_strobe_i && fbuf_q) begin
            flag_q <= 1'b1;
        end else if (instr_i.clear_flag_instr) begin
            flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fbuf_q <= 1'b0;
        end else if (instr_i.set_flag_instr || preset_io_pulse_i ||
                     flag_buffer_set_term) begin
            fbuf_q <= 1'b1;
        end else if (instr_i.clear_flag_instr ||
                     (interrupt_acknowledge_i && own_request_active)) begin
            fbuf_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_q <= 1'b0;
        end else if (request_phase_strobe_i && flag_q && fbuf_q &&
                     ctl_q && priority_in_i && interrupt_system_on_i) begin
            irq_q <= 1'b1;
        end else if (phase_two_strobe_i) begin
            irq_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_a_o <= 1'b0;
            irq_b_o <= 1'b0;
            priority_out_o <= 1'b1;
            skip_response_o <= 1'b0;
        end else begin
            irq_a_o <= irq_q;
            irq_b_o <= irq_q;
            priority_out_o <= priority_in_i &&
                !(ctl_q && flag_q && interrupt_system_on_i);
            skip_response_o <=
                (instr_i.skip_if_flag_set_instr && flag_q) ||
                (instr_i.skip_if_flag_clear_instr && !flag_q &&
                 !restrict_q);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_q <= 1'b0;
        end else if (instr_i.clear_control_instr ||
                     global_control_reset_i) begin
            ctl_q <= 1'b0;
        end else if (instr_i.set_control_instr) begin
            ctl_q <= 1'b1;
        end
    end

    // Guard outlives the instruction until the next T2
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            guard_q <= 1'b0;
        end else if (instr_i.clear_control_instr &&
                     instr_i.clear_flag_instr) begin
            guard_q <= 1'b1;
        end else if (phase_two_strobe_i) begin
            guard_q <= 1'b0;
        end
    end

    // With the guard clear, a lone clear-flag opens the input without commands
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            active_q <= 1'b0;
        end else if (instr_i.clear_control_instr) begin
            active_q <= 1'b0;
        end else if (instr_i.set_control_instr ||
                     (instr_i.clear_flag_instr && !guard_q)) begin
            active_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            input_active_o <= 1'b0;
            fifo_empty_force_o <= 1'b1;
            in_reg_clear_o <= 1'b1;
        end else begin
            input_active_o <= active_q;
            fifo_empty_force_o <= !active_q;
            in_reg_clear_o <= !active_q &&
                !interface_read_strobe_i;
        end
    end

    // Edge only: a held flag gives a single pulse
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_prev_q <= 1'b0;
            fp_cnt_q <= '0;
        end else begin
            flag_prev_q <= ~device_flag_n_i;
            if (flag_edge) begin
                fp_cnt_q <= PULSE_CYC;
            end else if (fp_cnt_q != '0) begin
                fp_cnt_q <= fp_cnt_q - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flag_edge_pulse_o <= 1'b0;
        end else begin
            flag_edge_pulse_o <= flag_edge || fp_cnt_q > 1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctl_prev_q <= 1'b0;
            trig_prev_q <= 1'b0;
        end else begin
            ctl_prev_q <= ctl_q;
            trig_prev_q <= next_command_trigger_i;
        end
    end

    // Delay keeps next command clear of the flag edge
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dly_q <= ifc_pkg::DLY_IDLE;
            dly_cnt_q <= '0;
        end else if (!ctl_q) begin
            dly_q <= ifc_pkg::DLY_IDLE;
            dly_cnt_q <= '0;
        end else begin
            case (dly_q)
                ifc_pkg::DLY_IDLE: begin
                    if (trig_edge) begin
                        dly_q <= ifc_pkg::DLY_WAIT;
                        dly_cnt_q <= PULSE_CYC;
                    end
                end
                ifc_pkg::DLY_WAIT: begin
                    dly_cnt_q <= dly_cnt_q - 1'b1;
                    if (dly_cnt_q == `IFC_CNT_W'(1)) begin
                        dly_q <= ifc_pkg::DLY_IDLE;
                    end
                end
                default: begin
                    dly_q <= ifc_pkg::DLY_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd1_q <= 1'b0;
            cmd2_q <= 1'b0;
        end else if (!ctl_q) begin
            cmd1_q <= 1'b0;
            cmd2_q <= 1'b0;
        end else if (flag_edge) begin
            cmd1_q <= 1'b0;
            cmd2_q <= 1'b0;
        end else begin
            if (!ctl_prev_q) begin
                cmd1_q <= 1'b1;
            end
            if (dly_q == ifc_pkg::DLY_WAIT &&
                dly_cnt_q == `IFC_CNT_W'(1)) begin
                cmd2_q <= 1'b1;
            end
        end
    end

    // Pin only pulls low; pull-up is off chip
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            device_command_n_o <= 1'b0;
            device_command_oe_n_o <= 1'b1;
            command_led_o <= 1'b0;
        end else begin
            device_command_n_o <= 1'b0;
            device_command_oe_n_o <= !cmd_any;
            command_led_o <= !device_command_n_i;
        end
    end

    // Ages counted here; long repeats would choke the tools
    logic [`IFC_CNT_W-1:0] edge_age_q;
    logic [`IFC_CNT_W-1:0] trig_age_q;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            edge_age_q <= '1;
        end else if (flag_edge) begin
            edge_age_q <= '0;
        end else if (edge_age_q != '1) begin
            edge_age_q <= edge_age_q + 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trig_age_q <= '0;
        end else if (trig_edge && ctl_q && dly_q == ifc_pkg::DLY_IDLE) begin
            trig_age_q <= `IFC_CNT_W'(1);
        end else if (trig_age_q != '0 && trig_age_q <= PULSE_CYC &&
                     ctl_q && !flag_edge) begin
            trig_age_q <= trig_age_q + 1'b1;
        end else begin
            trig_age_q <= '0;
        end
    end

    sequence s_t2_with_buf;
        phase_two_strobe_i && fbuf_q;
    endsequence

    property p_flag_set;
        @(posedge clk_i) disable iff (rst_i)
        s_t2_with_buf |=> flag_q;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("flag did not set at T2");

    property p_flag_clr;
        @(posedge clk_i) disable iff (rst_i)
        instr_i.clear_flag_instr && !phase_two_strobe_i |=> !flag_q;
    endproperty
    a_flag_clr: assert property (p_flag_clr)
        else $error("flag not cleared");

    property p_fbuf_ack;
        @(posedge clk_i) disable iff (rst_i)
        interrupt_acknowledge_i && irq_q && !instr_i.set_flag_instr &&
        !preset_io_pulse_i && !flag_buffer_set_term |=> !fbuf_q;
    endproperty
    a_fbuf_ack: assert property (p_fbuf_ack)
        else $error("flag buffer survived acknowledge");

    property p_irq_cond;
        @(posedge clk_i) disable iff (rst_i)
        $rose(irq_q) |-> $past(flag_q && fbuf_q && ctl_q &&
            priority_in_i && interrupt_system_on_i &&
            request_phase_strobe_i);
    endproperty
    a_irq_cond: assert property (p_irq_cond)
        else $error("request set without all conditions");

    property p_irq_t2;
        @(posedge clk_i) disable iff (rst_i)
        phase_two_strobe_i && !request_phase_strobe_i |=> !irq_q;
    endproperty
    a_irq_t2: assert property (p_irq_t2)
        else $error("request not reset at T2");

    property p_prio;
        @(posedge clk_i) disable iff (rst_i)
        !priority_in_i |=> !priority_out_o;
    endproperty
    a_prio: assert property (p_prio)
        else $error("priority out not low");

    property p_skip_restrict;
        @(posedge clk_i) disable iff (rst_i)
        restrict_q && !instr_i.skip_if_flag_set_instr |=>
            !skip_response_o;
    endproperty
    a_skip_restrict: assert property (p_skip_restrict)
        else $error("restricted skip-if-clear skipped");

    property p_cmd_ctl;
        @(posedge clk_i) disable iff (rst_i)
        !ctl_q |=> !cmd1_q && !cmd2_q ##1 device_command_oe_n_o;
    endproperty
    a_cmd_ctl: assert property (p_cmd_ctl)
        else $error("command active without control");

    property p_first_cmd;
        @(posedge clk_i) disable iff (rst_i)
        $rose(ctl_q) && !flag_edge |=> cmd1_q ##1 !device_command_oe_n_o;
    endproperty
    a_first_cmd: assert property (p_first_cmd)
        else $error("first command missing");

    property p_pulse_len;
        @(posedge clk_i) disable iff (rst_i)
        flag_edge_pulse_o == (edge_age_q < PULSE_CYC);
    endproperty
    a_pulse_len: assert property (p_pulse_len)
        else $error("flag pulse length wrong");

    property p_next_cmd;
        @(posedge clk_i) disable iff (rst_i)
        trig_age_q == PULSE_CYC + 1'b1 |-> cmd2_q;
    endproperty
    a_next_cmd: assert property (p_next_cmd)
        else $error("next command not after delay");

endmodule

// *** hw/ifc_consts.svh ***
`ifndef IFC_CONSTS_SVH
`define IFC_CONSTS_SVH

`define IFC_CLK_MHZ 125
`define IFC_PULSE_NS 100
`define IFC_PULSE_CYC ((`IFC_PULSE_NS * `IFC_CLK_MHZ + 999) / 1000)
`define IFC_CNT_W 5

`define IFC_ADR_CTRL 4'h0
`define IFC_ADR_STAT 4'h4
`define IFC_ADR_W 4

`define IFC_CTRL_RESTRICT 0
`define IFC_CTRL_RESET 32'h0000_0001

`define IFC_ST_FLAG 0
`define IFC_ST_FBUF 1
`define IFC_ST_CTL 2
`define IFC_ST_IRQ 3
`define IFC_ST_ACTIVE 4
`define IFC_ST_CMD1 5
`define IFC_ST_CMD2 6
`define IFC_ST_GUARD 7
`define IFC_ST_FULL 8

`endif

// *** hw/ifc_pkg.sv ***
package ifc_pkg;

    typedef struct packed {
        logic set_control_instr;
        logic clear_control_instr;
        logic set_flag_instr;
        logic clear_flag_instr;
        logic skip_if_flag_set_instr;
        logic skip_if_flag_clear_instr;
    } ifc_instr_t;

    typedef enum logic [0:0] {
        DLY_IDLE = 1'b0,
        DLY_WAIT = 1'b1
    } ifc_dly_t;

endpackage

// *** sim/ifc_src_model.sv ***
module ifc_src_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cmd_n_i,
    input wire logic [3:0] dly_i,
    output logic flag_n_o,
    output logic trig_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [1:0] st_q;
    logic [4:0] cnt_q;
    // Answer delay set by the bench: prompt or slow source
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_q <= 2'h0;
            cnt_q <= 5'h00;
            flag_n_o <= 1'b1;
            trig_o <= 1'b0;
        end else begin
            cnt_q <= cnt_q + 5'h01;
            case (st_q)
                // Flag answers a held command
                2'h0: begin
                    if (cmd_n_i) begin
                        cnt_q <= 5'h00;
                    end else if (cnt_q[3:0] == dly_i) begin
                        st_q <= 2'h1;
                        cnt_q <= 5'h00;
                        flag_n_o <= 1'b0;
                    end
                end
                2'h1: begin
                    if (cnt_q == 5'h02) begin
                        st_q <= 2'h2;
                        cnt_q <= 5'h00;
                        flag_n_o <= 1'b1;
                    end
                end
                // Word leaves the input register late
                default: begin
                    trig_o <= (cnt_q >= 5'h0F);
                    if (cnt_q == 5'h11) begin
                        st_q <= 2'h0;
                        cnt_q <= 5'h00;
                    end
                end
            endcase
        end
    end
endmodule

// *** sim/testbench.sv ***
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [5:0] SET_CTL = 6'h20, CLR_CTL = 6'h10, SET_FLG = 6'h08;
    localparam logic [5:0] CLR_FLG = 6'h04, SKP_SET = 6'h02, SKP_CLR = 6'h01;
    localparam logic [4:0] T2 = 5'h01, T5 = 5'h02, INT_ACK = 5'h04;
    localparam logic [4:0] PRE = 5'h08, CTL_RST = 5'h10;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [31:0] adr = 32'h0, wdat = 32'h0, rdat, d;
    ifc_pkg::ifc_instr_t ins = 6'h00;
    logic [4:0] ev = 5'h00;
    logic [3:0] dly = 4'h6;
    logic int_on = 1'b0, prio_in = 1'b1, rds = 1'b0, reg_full = 1'b0;
    logic ext_n = 1'b1;
    logic ack, cmd_n, oe_n, led, fep, irq_a, irq_b, pout, skip;
    logic act, fef, irc, flag_n, trig, line;
    int n_errors = 0, tests_run = 0, k, n;
    always #4 clk_i = ~clk_i;
    // Pulled-up command line, another controller may also pull it
    assign line = (oe_n | cmd_n) & ext_n;
    ifc_card i_ifc_card (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(adr),
        .wb_dat_i(wdat), .wb_sel_i(4'hF), .wb_we_i(we), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_dat_o(rdat), .wb_ack_o(ack), .instr_i(ins),
        .phase_two_strobe_i(ev[0]), .request_phase_strobe_i(ev[1]),
        .interrupt_acknowledge_i(ev[2]), .preset_io_pulse_i(ev[3]),
        .global_control_reset_i(ev[4]), .interrupt_system_on_i(int_on),
        .priority_in_i(prio_in), .interface_read_strobe_i(rds),
        .register_full_i(reg_full), .next_command_trigger_i(trig),
        .device_flag_n_i(flag_n), .device_command_n_i(line),
        .device_command_n_o(cmd_n), .device_command_oe_n_o(oe_n),
        .command_led_o(led), .flag_edge_pulse_o(fep), .irq_a_o(irq_a),
        .irq_b_o(irq_b), .priority_out_o(pout), .skip_response_o(skip),
        .input_active_o(act), .fifo_empty_force_o(fef),
        .in_reg_clear_o(irc));
    ifc_src_model i_ifc_src_model (.clk_i(clk_i), .rst_i(rst_i),
        .cmd_n_i(line), .dly_i(dly), .flag_n_o(flag_n), .trig_o(trig));
    task stop_test;
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task fail;
        n_errors++;
        stop_test();
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            $display("Error at %0t got %h expected %h", $time, g, e);
            n_errors++;
        end
    endtask
    task wb(input logic w, input logic [31:0] a, input logic [31:0] v);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= v;
        for (k = 0; k < 20; k++) begin
            @(posedge clk_i);
            if (ack === 1'b1) break;
        end
        d = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
        if (k == 20) fail();
    endtask
    task go(input logic [5:0] i, input logic [4:0] e);
        @(posedge clk_i);
        ins <= i;
        ev <= e;
        @(posedge clk_i);
        ins <= 6'h00;
        ev <= 5'h00;
        #1;
    endtask
    // Bounded wait: 0 line, 1 flag pulse, 2 trigger
    task wt(input int s, input logic v);
        for (k = 0; k < 60; k++) begin
            @(posedge clk_i);
            if ((s == 0 ? line : s == 1 ? fep : trig) === v) break;
        end
        if (k == 60) fail();
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        #1;
        chk({oe_n, pout, fef, irc, act, skip}, 32'h3C);
        chk(cmd_n, 32'h0);
        wb(1'b0, 32'h0, 32'h0); chk(d, 32'h1);
        wb(1'b1, 32'h8, 32'h5);
        wb(1'b0, 32'h8, 32'h0); chk(d, 32'h0);
        go(SET_CTL, 5'h00); wt(0, 1'b0);
        #1; chk(led, 32'h1);
        wt(1, 1'b1);
        for (n = 1; n < 40; n++) begin
            @(posedge clk_i);
            if (fep !== 1'b1) break;
        end
        chk(n, 32'd13);
        chk(oe_n, 32'h1);
        dly <= 4'h0;
        wt(2, 1'b1);
        for (n = 1; n < 40; n++) begin
            @(posedge clk_i);
            if (line === 1'b0) break;
        end
        chk(n >= 13 && n <= 17, 32'h1);
        go(SET_FLG, 5'h00);
        wb(1'b0, 32'h4, 32'h0); chk(d[1:0], 32'h2);
        go(6'h00, T2);
        wb(1'b0, 32'h4, 32'h0); chk(d[1:0], 32'h3);
        go(SKP_SET, 5'h00); chk(skip, 32'h1);
        go(SKP_CLR, 5'h00); chk(skip, 32'h0);
        @(posedge clk_i);
        int_on <= 1'b1;
        go(6'h00, T5); chk(pout, 32'h0);
        @(posedge clk_i);
        #1; chk({irq_a, irq_b}, 32'h3);
        go(6'h00, T2);
        @(posedge clk_i);
        #1; chk({irq_a, irq_b}, 32'h0);
        go(6'h00, T5);
        go(6'h00, INT_ACK);
        wb(1'b0, 32'h4, 32'h0); chk(d[1:0], 32'h1);
        go(6'h00, T2);
        go(6'h00, T5);
        @(posedge clk_i);
        #1; chk({irq_a, irq_b}, 32'h0);
        go(CLR_FLG, 5'h00);
        @(posedge clk_i);
        #1; chk(pout, 32'h1);
        @(posedge clk_i);
        prio_in <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1; chk(pout, 32'h0);
        @(posedge clk_i);
        prio_in <= 1'b1;
        reg_full <= 1'b1;
        wb(1'b0, 32'h4, 32'h0); chk(d[1:0], 32'h2);
        reg_full <= 1'b0;
        go(CLR_FLG, 5'h00);
        go(6'h00, PRE);
        wb(1'b0, 32'h4, 32'h0); chk(d[1:0], 32'h2);
        wb(1'b1, 32'h0, 32'h0);
        go(SKP_CLR, 5'h00); chk(skip, 32'h1);
        go(6'h00, CTL_RST);
        wb(1'b0, 32'h4, 32'h0); chk(d[2], 32'h0);
        chk(oe_n, 32'h1);
        go(CLR_CTL, 5'h00);
        @(posedge clk_i);
        #1; chk({act, fef}, 32'h1);
        go(CLR_FLG, 5'h00);
        @(posedge clk_i);
        #1; chk(act, 32'h1);
        go(CLR_CTL | CLR_FLG, 5'h00);
        @(posedge clk_i);
        #1; chk(act, 32'h0);
        go(CLR_FLG, 5'h00);
        @(posedge clk_i);
        #1; chk(act, 32'h0);
        go(6'h00, T2);
        go(CLR_FLG, 5'h00);
        @(posedge clk_i);
        #1; chk(act, 32'h1);
        @(posedge clk_i);
        rds <= 1'b1;
        go(CLR_CTL, 5'h00);
        @(posedge clk_i);
        #1; chk(irc, 32'h0);
        @(posedge clk_i);
        rds <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1; chk(irc, 32'h1);
        @(posedge clk_i);
        ext_n <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1; chk({led, oe_n}, 32'h3);
        @(posedge clk_i);
        ext_n <= 1'b1;
        stop_test();
    end
endmodule
